// [verilog/efr_consts.svh]
// offsets, field positions, reset values and format codes of the frame unit
`ifndef EFR_CONSTS_SVH
`define EFR_CONSTS_SVH

// format field codes of the format/vector word
`define EFR_FMT_FOUR       4'h0
`define EFR_FMT_THROW      4'h1
`define EFR_FMT_SIX        4'h2
`define EFR_FMT_EIGHT      4'h4

// frame sizes in bytes
`define EFR_SIZE_FOUR      32'h0000_0008
`define EFR_SIZE_SIX       32'h0000_000C
`define EFR_SIZE_EIGHT     32'h0000_0010

// byte offsets of the long words inside a frame, and the address error adjustment
`define EFR_OFS_SR_LONG    32'h0000_0000
`define EFR_OFS_FV_LONG    32'h0000_0004
`define EFR_OFS_ADDR       32'h0000_0008
`define EFR_OFS_FPC        32'h0000_000C
`define EFR_ADDR_ERR_ADJ   32'h0000_0001

// status register and format/vector field positions
`define EFR_SR_S_BIT       13
`define EFR_SR_M_BIT       12
`define EFR_FV_FMT_MSB     15
`define EFR_FV_FMT_LSB     12

// register port map
`define EFR_REG_STATUS     4'h0
`define EFR_REG_SR         4'h1
`define EFR_REG_PC         4'h2
`define EFR_REG_CTRL       4'h3
`define EFR_REG_ISP        4'h4
`define EFR_REG_MSP        4'h5
`define EFR_REG_USP        4'h6
`define EFR_CTRL_EN_BIT    0
`define EFR_CTRL_CLR_BIT   8
`define EFR_CTRL_EN_RST    1'h1

`endif

// [verilog/efr_pkg.sv]
// types shared by the frame unit modules
package efr_pkg;

	typedef enum logic [1:0]
	{
		EFR_STK_USER,
		EFR_STK_INT,
		EFR_STK_MASTER
	} efr_stack_type;

	typedef enum logic [2:0]
	{
		EFR_KIND_PLAIN,
		EFR_KIND_INTERRUPT,
		EFR_KIND_TRAP,
		EFR_KIND_ADDR_ERR,
		EFR_KIND_FP_UNIMPL
	} efr_kind_type;

	typedef enum logic [2:0]
	{
		EFR_IDLE,
		EFR_RD_FV,
		EFR_CHECK,
		EFR_RD_SR,
		EFR_RETIRE,
		EFR_BUILD,
		EFR_WR
	} efr_state_type;

endpackage

// [verilog/efr_frame_decode.sv]
// format nibble decoder: frame size, validity and throwaway flag
`include "efr_consts.svh"

module efr_frame_decode
(
	// format/vector word
	input  wire logic [15:0] fv_word,
	// decoded format
	output logic      [3:0]  fmt,
	output logic      [31:0] size,
	output logic             valid,
	output logic             throwaway
);
	function automatic logic [31:0] frame_size(input logic [3:0] f);
		case (f)
			`EFR_FMT_FOUR:  frame_size = `EFR_SIZE_FOUR;
			`EFR_FMT_THROW: frame_size = `EFR_SIZE_FOUR;
			`EFR_FMT_SIX:   frame_size = `EFR_SIZE_SIX;
			`EFR_FMT_EIGHT: frame_size = `EFR_SIZE_EIGHT;
			default:        frame_size = 32'h0000_0000;
		endcase
	endfunction

	assign fmt       = fv_word[`EFR_FV_FMT_MSB:`EFR_FV_FMT_LSB];
	assign size      = frame_size(fmt);
	// unknown formats have no size and are refused
	assign valid     = (frame_size(fmt) != 32'h0000_0000);
	assign throwaway = (fmt == `EFR_FMT_THROW);
endmodule

// [verilog/efr_frame_pack.sv]
// picks one long word of a frame being built
`include "efr_consts.svh"

module efr_frame_pack
(
	// frame contents
	input  wire logic [3:0]  fmt,
	input  wire logic [11:0] vector,
	input  wire logic [15:0] sr,
	input  wire logic [31:0] pc,
	input  wire logic [31:0] addr_field,
	input  wire logic [31:0] fault_pc,
	// long word index, 0 at the stack pointer
	input  wire logic [1:0]  idx,
	output logic      [31:0] word
);
	wire [31:0] long0 = {sr, pc[31:16]};
	wire [31:0] long1 = {pc[15:0], fmt, vector};

	assign word = (idx == 2'h0) ? long0 :
	              (idx == 2'h1) ? long1 :
	              (idx == 2'h2) ? addr_field : fault_pc;
endmodule

// [verilog/efr_return_unit.sv]
// exception frame build and return-from-exception sequencer
`include "efr_consts.svh"

module efr_return_unit
(
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	// register port
	input  wire logic [3:0]            reg_addr,
	input  wire logic [31:0]           reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [31:0]           reg_rdata,
	// core context at request time
	input  wire logic [15:0]           sr_in,
	input  wire logic [31:0]           isp_in,
	input  wire logic [31:0]           msp_in,
	input  wire logic [31:0]           usp_in,
	// return request
	input  wire logic                  rte_start,
	// frame build request
	input  wire logic                  build_start,
	input  wire efr_pkg::efr_kind_type build_kind,
	input  wire logic [11:0]           build_vector,
	input  wire logic [31:0]           build_pc_next,
	input  wire logic [31:0]           build_pc_fault,
	input  wire logic [31:0]           build_addr,
	// memory port
	output logic                       mem_req,
	output logic                       mem_we,
	output logic                       mem_long,
	output logic      [31:0]           mem_addr,
	output logic      [31:0]           mem_wdata,
	input  wire logic [31:0]           mem_rdata,
	input  wire logic                  mem_ack,
	// results
	output logic                       busy,
	output logic                       done,
	output logic                       fmt_err,
	output logic      [15:0]           sr_out,
	output logic      [31:0]           pc_out,
	output logic      [31:0]           isp_out,
	output logic      [31:0]           msp_out,
	output logic      [31:0]           usp_out
);
	import efr_pkg::*;

	function automatic efr_stack_type stack_of(input logic [15:0] s);
		if (!s[`EFR_SR_S_BIT])
			stack_of = EFR_STK_USER;
		else if (s[`EFR_SR_M_BIT])
			stack_of = EFR_STK_MASTER;
		else
			stack_of = EFR_STK_INT;
	endfunction

	efr_state_type state_ff;
	efr_state_type nxt_state;
	efr_stack_type stk_ff;
	efr_stack_type nxt_stk;
	logic [31:0]   sp_ff [0:2];
	logic [15:0]   sr_ff;
	logic [15:0]   nxt_sr;
	logic [15:0]   sr_new_ff;
	logic [15:0]   nxt_sr_new;
	logic [31:0]   pc_ff;
	logic [31:0]   nxt_pc;
	logic [15:0]   fv_ff;
	logic [15:0]   nxt_fv;
	logic [15:0]   pcl_ff;
	logic [15:0]   nxt_pcl;
	logic          req_ff;
	logic          nxt_req;
	logic          we_ff;
	logic          nxt_we;
	logic [31:0]   addr_ff;
	logic [31:0]   nxt_addr;
	logic [31:0]   wdata_ff;
	logic [31:0]   nxt_wdata;
	logic          done_ff;
	logic          nxt_done;
	logic          busy_ff;
	logic          err_evt;
	logic          fmt_err_ff;
	logic          en_ff;
	logic [7:0]    throw_cnt_ff;
	logic          throw_evt;
	logic [31:0]   rdata_ff;
	logic          sp_we;
	logic [31:0]   sp_val;
	// frame being built
	logic [3:0]    bfmt_ff;
	logic [3:0]    nxt_bfmt;
	logic [11:0]   bvec_ff;
	logic [31:0]   bpc_ff;
	logic [31:0]   baddr_ff;
	logic [31:0]   bfpc_ff;
	logic          chain_ff;
	logic          nxt_chain;
	logic [31:0]   base_ff;
	logic [31:0]   nxt_base;
	logic [1:0]    idx_ff;
	logic [1:0]    nxt_idx;

	// decoded views
	wire           start_ok  = (state_ff == EFR_IDLE) && en_ff;
	wire           take_rte  = start_ok && rte_start;
	wire           take_bld  = start_ok && !rte_start && build_start;
	wire [31:0]    sp_act    = sp_ff[stk_ff];
	wire [3:0]     rd_fmt;
	wire [31:0]    rd_size;
	wire           rd_valid;
	wire           rd_throw;
	wire [3:0]     bd_fmt;
	wire [31:0]    bd_size;
	wire [31:0]    pack_word;
	wire [1:0]     last_idx  = bd_size[3:2] - 2'h1;
	wire           ctrl_hit  = reg_wr && (reg_addr == `EFR_REG_CTRL);
	wire           clr_err   = ctrl_hit && reg_wdata[`EFR_CTRL_CLR_BIT];
	wire           from_mstr = sr_in[`EFR_SR_S_BIT] && sr_in[`EFR_SR_M_BIT];
	wire [31:0]    status_w  = {8'h00, throw_cnt_ff, 4'h0, rd_fmt,
	                            1'b0, state_ff, 2'h0, fmt_err_ff,
	                            (state_ff != EFR_IDLE)};
	wire [31:0]    rd_mux    =
		(reg_addr == `EFR_REG_STATUS) ? status_w :
		(reg_addr == `EFR_REG_SR)     ? {16'h0000, sr_ff} :
		(reg_addr == `EFR_REG_PC)     ? pc_ff :
		(reg_addr == `EFR_REG_CTRL)   ? {31'h0000_0000, en_ff} :
		(reg_addr == `EFR_REG_ISP)    ? sp_ff[EFR_STK_INT] :
		(reg_addr == `EFR_REG_MSP)    ? sp_ff[EFR_STK_MASTER] :
		(reg_addr == `EFR_REG_USP)    ? sp_ff[EFR_STK_USER] :
		32'h0000_0000;

	// format nibble of the fetched word
	efr_frame_decode u_rd_decode
	(
		.fv_word   (fv_ff),
		.fmt       (rd_fmt),
		.size      (rd_size),
		.valid     (rd_valid),
		.throwaway (rd_throw)
	);

	efr_frame_decode u_bd_decode
	(
		.fv_word   ({bfmt_ff, 12'h000}),
		.fmt       (bd_fmt),
		.size      (bd_size),
		.valid     (),
		.throwaway ()
	);

	// frame words laid out per format
	efr_frame_pack u_pack
	(
		.fmt        (bd_fmt),
		.vector     (bvec_ff),
		.sr         (sr_ff),
		.pc         (bpc_ff),
		.addr_field (baddr_ff),
		.fault_pc   (bfpc_ff),
		.idx        (idx_ff),
		.word       (pack_word)
	);

	always_comb
	begin
		nxt_state  = state_ff;
		nxt_stk    = stk_ff;
		nxt_sr     = sr_ff;
		nxt_sr_new = sr_new_ff;
		nxt_pc     = pc_ff;
		nxt_fv     = fv_ff;
		nxt_pcl    = pcl_ff;
		nxt_req    = req_ff;
		nxt_we     = we_ff;
		nxt_addr   = addr_ff;
		nxt_wdata  = wdata_ff;
		nxt_done   = 1'b0;
		err_evt    = 1'b0;
		throw_evt  = 1'b0;
		sp_we      = 1'b0;
		sp_val     = sp_act;
		nxt_bfmt   = bfmt_ff;
		nxt_chain  = chain_ff;
		nxt_base   = base_ff;
		nxt_idx    = idx_ff;
		case (state_ff)
			EFR_IDLE:
			begin
				if (take_rte)
				begin
					nxt_sr    = sr_in;
					nxt_stk   = stack_of(sr_in);
					nxt_state = EFR_RD_FV;
				end
				else if (take_bld)
				begin
					nxt_sr    = sr_in;
					nxt_stk   = stack_of(sr_in);
					nxt_chain = 1'b0;
					nxt_state = EFR_BUILD;
					case (build_kind)
						EFR_KIND_TRAP:      nxt_bfmt = `EFR_FMT_SIX;
						EFR_KIND_ADDR_ERR:  nxt_bfmt = `EFR_FMT_SIX;
						EFR_KIND_FP_UNIMPL: nxt_bfmt = `EFR_FMT_EIGHT;
						EFR_KIND_INTERRUPT:
						begin
							nxt_bfmt  = `EFR_FMT_FOUR;
							nxt_chain = from_mstr;
						end
						default:            nxt_bfmt = `EFR_FMT_FOUR;
					endcase
				end
			end
			EFR_RD_FV:
			begin
				// format long word is fetched first
				if (!req_ff)
				begin
					nxt_req  = 1'b1;
					nxt_we   = 1'b0;
					nxt_addr = sp_act + `EFR_OFS_FV_LONG;
				end
				else if (mem_ack)
				begin
					nxt_req        = 1'b0;
					// pc is held aside so a refused frame leaves it alone
					nxt_pcl        = mem_rdata[31:16];
					nxt_fv         = mem_rdata[15:0];
					nxt_state      = EFR_CHECK;
				end
			end
			EFR_CHECK:
			begin
				if (!rd_valid)
				begin
					err_evt   = 1'b1;
					nxt_done  = 1'b1;
					nxt_state = EFR_IDLE;
				end
				else
					nxt_state = EFR_RD_SR;
			end
			EFR_RD_SR:
			begin
				if (!req_ff)
				begin
					nxt_req  = 1'b1;
					nxt_we   = 1'b0;
					nxt_addr = sp_act + `EFR_OFS_SR_LONG;
				end
				else if (mem_ack)
				begin
					nxt_req       = 1'b0;
					nxt_sr_new    = mem_rdata[31:16];
					nxt_pc        = {mem_rdata[15:0], pcl_ff};
					nxt_state     = EFR_RETIRE;
				end
			end
			EFR_RETIRE:
			begin
				sp_we  = 1'b1;
				sp_val = sp_act + rd_size;
				nxt_sr = sr_new_ff;
				if (rd_throw)
				begin
					// restart on the stack the new status picks
					throw_evt = 1'b1;
					// any format, any of the three stacks
					nxt_stk   = stack_of(sr_new_ff);
					nxt_state = EFR_RD_FV;
				end
				else
				begin
					nxt_done  = 1'b1;
					nxt_state = EFR_IDLE;
				end
			end
			EFR_BUILD:
			begin
				// stack pointer is dropped before the words are stored
				sp_we     = 1'b1;
				sp_val    = sp_act - bd_size;
				nxt_base  = sp_act - bd_size;
				nxt_idx   = last_idx;
				nxt_state = EFR_WR;
			end
			EFR_WR:
			begin
				// every frame word goes out as a long word
				if (!req_ff)
				begin
					nxt_req   = 1'b1;
					nxt_we    = 1'b1;
					nxt_addr  = base_ff + {28'h000_0000, idx_ff, 2'b00};
					nxt_wdata = pack_word;
				end
				else if (mem_ack)
				begin
					nxt_req = 1'b0;
					nxt_we  = 1'b0;
					if (idx_ff != 2'h0)
						nxt_idx = idx_ff - 2'h1;
					else if (chain_ff)
					begin
						// throwaway copy on the interrupt stack
						nxt_chain = 1'b0;
						nxt_bfmt  = `EFR_FMT_THROW;
						nxt_stk   = EFR_STK_INT;
						nxt_state = EFR_BUILD;
					end
					else
					begin
						nxt_done  = 1'b1;
						nxt_state = EFR_IDLE;
					end
				end
			end
			default:
				nxt_state = EFR_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_ff  <= EFR_IDLE;
			stk_ff    <= EFR_STK_INT;
			sr_ff     <= 16'h0000;
			sr_new_ff <= 16'h0000;
			pc_ff     <= 32'h0000_0000;
			fv_ff     <= 16'h0000;
			pcl_ff    <= 16'h0000;
			bfmt_ff   <= `EFR_FMT_FOUR;
			chain_ff  <= 1'b0;
			base_ff   <= 32'h0000_0000;
			idx_ff    <= 2'h0;
		end
		else
		begin
			state_ff  <= nxt_state;
			stk_ff    <= nxt_stk;
			sr_ff     <= nxt_sr;
			sr_new_ff <= nxt_sr_new;
			pc_ff     <= nxt_pc;
			fv_ff     <= nxt_fv;
			pcl_ff    <= nxt_pcl;
			bfmt_ff   <= nxt_bfmt;
			chain_ff  <= nxt_chain;
			base_ff   <= nxt_base;
			idx_ff    <= nxt_idx;
		end
	end

	// build fields latched at request time
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bvec_ff  <= 12'h000;
			bpc_ff   <= 32'h0000_0000;
			baddr_ff <= 32'h0000_0000;
			bfpc_ff  <= 32'h0000_0000;
		end
		else if (take_bld)
		begin
			bvec_ff  <= build_vector;
			bfpc_ff  <= build_pc_fault;
			bpc_ff   <= (build_kind == EFR_KIND_ADDR_ERR) ?
			            build_pc_fault : build_pc_next;
			baddr_ff <= (build_kind == EFR_KIND_ADDR_ERR) ?
			            build_addr - `EFR_ADDR_ERR_ADJ : build_addr;
		end
	end

	// stack pointers: loaded at a request, then moved by the frames
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sp_ff[EFR_STK_USER]   <= 32'h0000_0000;
			sp_ff[EFR_STK_INT]    <= 32'h0000_0000;
			sp_ff[EFR_STK_MASTER] <= 32'h0000_0000;
		end
		else if (take_rte || take_bld)
		begin
			sp_ff[EFR_STK_USER]   <= usp_in;
			sp_ff[EFR_STK_INT]    <= isp_in;
			sp_ff[EFR_STK_MASTER] <= msp_in;
		end
		else if (sp_we)
			sp_ff[stk_ff] <= sp_val;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			req_ff   <= 1'b0;
			we_ff    <= 1'b0;
			addr_ff  <= 32'h0000_0000;
			wdata_ff <= 32'h0000_0000;
			done_ff  <= 1'b0;
			busy_ff  <= 1'b0;
		end
		else
		begin
			req_ff   <= nxt_req;
			we_ff    <= nxt_we;
			addr_ff  <= nxt_addr;
			wdata_ff <= nxt_wdata;
			done_ff  <= nxt_done;
			busy_ff  <= (nxt_state != EFR_IDLE);
		end
	end

	// register port; a new error wins over a clear in the same cycle
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			en_ff        <= `EFR_CTRL_EN_RST;
			fmt_err_ff   <= 1'b0;
			throw_cnt_ff <= 8'h00;
			rdata_ff     <= 32'h0000_0000;
		end
		else
		begin
			if (ctrl_hit)
				en_ff <= reg_wdata[`EFR_CTRL_EN_BIT];
			fmt_err_ff   <= err_evt | (fmt_err_ff & ~clr_err);
			throw_cnt_ff <= throw_cnt_ff + {7'h00, throw_evt};
			rdata_ff     <= reg_rd ? rd_mux : 32'h0000_0000;
		end
	end

	assign reg_rdata = rdata_ff;
	assign mem_req   = req_ff;
	assign mem_we    = we_ff;
	// transfer size is always a long word
	assign mem_long  = req_ff;
	assign mem_addr  = addr_ff;
	assign mem_wdata = wdata_ff;
	assign busy      = busy_ff;
	assign done      = done_ff;
	assign fmt_err   = fmt_err_ff;
	assign sr_out    = sr_ff;
	assign pc_out    = pc_ff;
	assign isp_out   = sp_ff[EFR_STK_INT];
	assign msp_out   = sp_ff[EFR_STK_MASTER];
	assign usp_out   = sp_ff[EFR_STK_USER];
endmodule

// [verification/efr_mem_model.sv]
// memory model holding the supervisor stacks behind the frame unit
module efr_mem_model
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// answer delay in cycles
	input  wire logic [3:0]  lat,
	// memory port
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic        mem_long,
	input  wire logic [31:0] mem_addr,
	input  wire logic [31:0] mem_wdata,
	output logic      [31:0] mem_rdata,
	output logic             mem_ack
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [31:0] mem [0:255];
	logic [3:0]  wait_ff;
	logic [31:0] last_ff;

	assign mem_ack = mem_req && mem_long && wait_ff >= lat;
	// aligned stacks, low address bits unused
	// idle bus shows the inverse of the last word so stale data never matches
	assign mem_rdata = (mem_ack && !mem_we) ? mem[mem_addr[9:2]] : ~last_ff;

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wait_ff <= 4'h0;
			last_ff <= 32'h0;
		end
		else
		begin
			wait_ff <= (mem_req && !mem_ack) ? wait_ff + 4'h1 : 4'h0;
			if (mem_ack)
			begin
				last_ff <= mem_we ? mem_wdata : mem_rdata;
				if (mem_we)
					mem[mem_addr[9:2]] <= mem_wdata;
			end
		end
	end
endmodule

// [verification/efr_return_unit_checker.sv]
// port assertions for the frame return unit
module efr_return_unit_checker
(
	// clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// request side
	input wire logic        rte_start,
	input wire logic [15:0] sr_in,
	input wire logic [31:0] isp_in,
	input wire logic [31:0] msp_in,
	input wire logic [31:0] usp_in,
	// memory port
	input wire logic        mem_req,
	input wire logic        mem_we,
	input wire logic        mem_long,
	input wire logic [31:0] mem_addr,
	input wire logic        mem_ack,
	// results
	input wire logic        busy,
	input wire logic        done,
	input wire logic        fmt_err
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [31:0] sp_sel;

	assign sp_sel = !sr_in[13] ? usp_in : (sr_in[12] ? msp_in : isp_in);

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	long_xfer_a:
	assert property (mem_req |-> mem_long)
		else $error("frame access not long");
	req_hold_a:
	assert property (mem_req && !mem_ack |=>
		mem_req && $stable(mem_addr) && $stable(mem_we))
		else $error("request changed before ack");
	req_drop_a:
	assert property (mem_req && mem_ack |=> !mem_req)
		else $error("request held after ack");
	fv_first_a:
	assert property (rte_start && !busy |-> ##2 (!mem_req ||
		(!mem_we && mem_addr == $past(sp_sel, 2) + 32'h4)))
		else $error("format word not read first");
	fmt_done_a:
	assert property ($rose(fmt_err) |-> done)
		else $error("format error without done");
	done_pulse_a:
	assert property (done |=> !done)
		else $error("done longer than one cycle");
	done_idle_a:
	assert property (done |-> !busy && !mem_req)
		else $error("done while still active");
	busy_end_a:
	assert property ($fell(busy) |-> done)
		else $error("busy ended without done");
endmodule

bind efr_return_unit efr_return_unit_checker efr_return_unit_checker_inst
(
	.clk, .rst_n, .rte_start, .sr_in, .isp_in, .msp_in, .usp_in,
	.mem_req, .mem_we, .mem_long, .mem_addr, .mem_ack,
	.busy, .done, .fmt_err
);

// [verification/exception_frame_return_test.sv]
// self-checking bench for the exception frame return unit
`include "efr_consts.svh"

module exception_frame_return_test;
	timeunit 1ns;
	timeprecision 1ps;
	import efr_pkg::*;

	logic         clk, rst_n, reg_wr, reg_rd, rte_start, build_start;
	logic [3:0]   reg_addr, lat;
	logic [31:0]  reg_wdata, reg_rdata, isp_in, msp_in, usp_in;
	logic [15:0]  sr_in, sr_out;
	efr_kind_type build_kind;
	logic [11:0]  build_vector;
	logic [31:0]  build_pc_next, build_pc_fault, build_addr, pc_out;
	logic         mem_req, mem_we, mem_long, mem_ack, busy, done, fmt_err;
	logic [31:0]  mem_addr, mem_wdata, mem_rdata, isp_out, msp_out, usp_out;
	int           num_errors = 0;
	int           cmp_count = 0;

	efr_return_unit efr_return_unit_inst
	(
		.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.sr_in, .isp_in, .msp_in, .usp_in, .rte_start, .build_start,
		.build_kind, .build_vector, .build_pc_next, .build_pc_fault,
		.build_addr, .mem_req, .mem_we, .mem_long, .mem_addr, .mem_wdata,
		.mem_rdata, .mem_ack, .busy, .done, .fmt_err, .sr_out, .pc_out,
		.isp_out, .msp_out, .usp_out
	);
	efr_mem_model efr_mem_model_inst
	(
		.clk, .rst_n, .lat, .mem_req, .mem_we, .mem_long, .mem_addr,
		.mem_wdata, .mem_rdata, .mem_ack
	);

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	function automatic logic [31:0] mw(input logic [31:0] a);
		return efr_mem_model_inst.mem[a[9:2]];
	endfunction

	task automatic put(input logic [31:0] a, input logic [15:0] sr,
		input logic [31:0] pc, input logic [15:0] fv);
		efr_mem_model_inst.mem[a[9:2]] = {sr, pc[31:16]};
		efr_mem_model_inst.mem[a[9:2] + 8'h1] = {pc[15:0], fv};
	endtask

	// r high starts a return, low a frame build
	task automatic run(input logic r, input logic [15:0] sr,
		input logic [31:0] isp, input logic [31:0] msp);
		int n;
		@(posedge clk);
		sr_in <= sr;
		isp_in <= isp;
		msp_in <= msp;
		rte_start <= r;
		build_start <= !r;
		@(posedge clk);
		rte_start <= 1'b0;
		build_start <= 1'b0;
		for (n = 0; n < 200 && done !== 1'b1; n++)
			@(posedge clk) #1;
		check("done", {31'h0, done}, 32'h1);
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	task automatic t_formats;
		logic [3:0]  f[3] = '{`EFR_FMT_FOUR, `EFR_FMT_SIX, `EFR_FMT_EIGHT};
		logic [31:0] s[3] = '{32'h8, 32'hC, 32'h10};
		for (int i = 0; i < 3; i++)
		begin
			lat <= 4'(i);
			put(32'h100, 16'h2701, 32'h1234_5678 + 32'(i), {f[i], 12'h018});
			run(1'b1, 16'h2000, 32'h100, 32'h300);
			check("sr", {16'h0, sr_out}, 32'h2701);
			check("pc", pc_out, 32'h1234_5678 + 32'(i));
			check("isp", isp_out, 32'h100 + s[i]);
		end
		$display("t_formats finished");
	endtask

	task automatic t_throw;
		lat <= 4'h1;
		put(32'h200, 16'h3000, 32'h0, {`EFR_FMT_THROW, 12'h064});
		put(32'h300, 16'h2000, 32'h0, {`EFR_FMT_THROW, 12'h064});
		put(32'h208, 16'h2100, 32'hCAFE_0002, {`EFR_FMT_SIX, 12'h014});
		run(1'b1, 16'h2000, 32'h200, 32'h300);
		check("sr", {16'h0, sr_out}, 32'h2100);
		check("pc", pc_out, 32'hCAFE_0002);
		check("isp", isp_out, 32'h214);
		check("msp", msp_out, 32'h308);
		$display("t_throw finished");
	endtask

	task automatic t_bad;
		logic [31:0] d;
		put(32'h100, 16'h2700, 32'h0, 16'h7000);
		run(1'b1, 16'h2000, 32'h100, 32'h300);
		check("err", {31'h0, fmt_err}, 32'h1);
		check("isp", isp_out, 32'h100);
		check("pc", pc_out, 32'hCAFE_0002);
		check("usp", usp_out, 32'h380);
		rd(`EFR_REG_STATUS, d);
		check("stat", {31'h0, d[1]}, 32'h1);
		check("nib", {28'h0, d[11:8]}, 32'h7);
		check("cnt", {24'h0, d[23:16]}, 32'h2);
		rd(`EFR_REG_PC, d);
		check("rpc", d, 32'hCAFE_0002);
		wr(`EFR_REG_CTRL, 32'h101);
		rd(`EFR_REG_STATUS, d);
		check("clear", {31'h0, d[1]}, 32'h0);
		rd(`EFR_REG_CTRL, d);
		check("ctrl", d, 32'h1);
		rd(4'hF, d);
		check("hole", d, 32'h0);
		wr(`EFR_REG_CTRL, 32'h0);
		@(posedge clk);
		rte_start <= 1'b1;
		@(posedge clk);
		rte_start <= 1'b0;
		#1;
		check("off", {31'h0, busy}, 32'h0);
		wr(`EFR_REG_CTRL, 32'h1);
		$display("t_bad finished");
	endtask

	task automatic t_build;
		efr_kind_type k[3] = '{EFR_KIND_TRAP, EFR_KIND_ADDR_ERR,
			EFR_KIND_FP_UNIMPL};
		logic [31:0] b, p;
		for (int i = 0; i < 3; i++)
		begin
			@(posedge clk);
			build_kind <= k[i];
			run(1'b0, 16'h2004, 32'h200, 32'h300);
			b = isp_out;
			p = (i == 1) ? build_pc_fault : build_pc_next;
			check("sp", b, 32'h200 - (i == 2 ? 32'h10 : 32'hC));
			check("w0", mw(b), {16'h2004, p[31:16]});
			check("w1", mw(b + 4), {p[15:0], (i == 2) ? 4'h4 : 4'h2,
				12'h018});
			check("w2", mw(b + 8), build_addr - {31'h0, i == 1});
		end
		check("w3", mw(b + 12), build_pc_fault);
		@(posedge clk);
		build_kind <= EFR_KIND_INTERRUPT;
		run(1'b0, 16'h3000, 32'h200, 32'h300);
		check("msp", msp_out, 32'h2F8);
		check("isp", isp_out, 32'h1F8);
		b = mw(32'h1FC);
		check("thr", {b[31:12], 12'h0},
			{build_pc_next[15:0], 4'h1, 12'h0});
		run(1'b1, 16'h2000, 32'h1F8, 32'h2F8);
		check("sr", {16'h0, sr_out}, 32'h3000);
		check("pc", pc_out, build_pc_next);
		check("msp", msp_out, 32'h300);
		$display("t_build finished");
	endtask

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial
	begin
		{rst_n, reg_wr, reg_rd, rte_start, build_start} = 5'h00;
		{reg_addr, lat, reg_wdata} = 40'h0;
		{sr_in, isp_in, msp_in} = 80'h0;
		usp_in = 32'h380;
		build_kind = EFR_KIND_PLAIN;
		build_vector = 12'h018;
		build_pc_next = 32'h0011_1000;
		build_pc_fault = 32'h0022_0FFC;
		build_addr = 32'h5555_0000;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_formats;
		t_throw;
		t_bad;
		t_build;
		complete_run;
	end

	// the tests need a few hundred cycles; 20000 cycles means a hang
	initial
	begin
		#80000;
		num_errors++;
		complete_run;
	end
endmodule
